// ==== verilog/cond_code_accum_const_gen.sv ====
// Purpose: Execute stage for the condition accumulator, constants, byte compare and no-op assert.
// Assumes: One issue per cycle, operands already read from the register file.
// Notes: Accumulator reads are muxed in here; all outputs are registered.
`timescale 1ns/100ps
`include "ccg_map.svh"
module cond_code_accum_const_gen
   import ccg_pkg::*;
(
   input wire logic mclk, // core clock
   input wire logic reset, // synchronous reset
   input wire logic issue_valid, // instruction presented this cycle
   input wire issue_s issue, // decoded instruction and operands
   input wire logic fpu_denorm, // FPU operand or result is denormal
   input wire logic denormal_flush_select, // flush mode bit of the FP environment
   output result_s result, // registered integer result
   output logic [31:0] condition_code_accumulator, // accumulator contents
   output logic fpu_done, // FPU operation completion pulse
   output logic unsupported // registered flag for an unsupported accumulator use
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] bool_word(input logic t);
      return t ? `BOOL_TRUE : `WORD_ZERO;
   endfunction
   function automatic logic is_acc(input logic [7:0] r);
      return (r == `GREG_ACC_PLAIN) || (r == `GREG_ACC_SHIFT);
   endfunction
   function automatic logic lane_match(input logic [31:0] a, input logic [31:0] b);
      return (a[31:24] == b[31:24]) || (a[23:16] == b[23:16]) ||
         (a[15:8] == b[15:8]) || (a[7:0] == b[7:0]);
   endfunction

   logic [31:0] acc_r;
   logic [31:0] a_eff, b_eff, alu_out;
   logic fpu_busy, fpu_done_w, plain_ok, shift_ok, both_acc;
   logic [63:0] funnel;

   // ------------------------------------------------------------
   // Operand selection
   // ------------------------------------------------------------
   always_comb begin
      a_eff = issue.a_val;
      b_eff = issue.b_is_imm ? {24'h000000, issue.imm[`IMM8_W-1:0]} : issue.b_val;
      // FPU operations never see the accumulator; the shift alias reads as the
      // plain accumulator since any value is permitted there.
      if (issue.op != OP_FPU) begin
         if (is_acc(issue.src_a)) begin
            a_eff = acc_r;
         end
         if (!issue.b_is_imm && is_acc(issue.src_b)) begin
            b_eff = acc_r;
         end
      end
   end

   // ------------------------------------------------------------
   // Result datapath
   // ------------------------------------------------------------
   assign funnel = {a_eff, b_eff} << issue.shift_count;
   always_comb begin
      alu_out = `WORD_ZERO;
      unique case (issue.op)
         OP_ADD: alu_out = a_eff + b_eff;
         OP_SUB: alu_out = a_eff - b_eff;
         OP_CONST_LOW: alu_out = {`HALF_ZERO, issue.imm};
         OP_HIGH: alu_out = {issue.imm, issue.dest_old[`HALF_W-1:0]};
         OP_NEG: alu_out = {`HALF_ONES, issue.imm};
         OP_HIGH_ZERO: alu_out = {issue.imm, `HALF_ZERO};
         OP_BYTE_CMP: alu_out = bool_word(lane_match(a_eff, b_eff));
         // Byte alignment is left to software: a count with low bits 000 shifts by bytes.
         OP_FUNNEL: alu_out = funnel[63:32];
         OP_ASSERT_EQ: alu_out = `WORD_ZERO;
         OP_JUMP_REL: alu_out = issue.pc + {{14{issue.imm[`DISP_W-1]}}, issue.imm, 2'b00};
         OP_JUMP_IND: alu_out = a_eff;
         OP_LOAD: alu_out = b_eff;
         OP_FPU: alu_out = `WORD_ZERO;
         OP_LOGIC: alu_out = a_eff & b_eff;
      endcase
   end

   assign plain_ok = (issue.op == OP_ADD) || (issue.op == OP_SUB) ||
      (issue.op == OP_CONST_LOW) || (issue.op == OP_HIGH) ||
      (issue.op == OP_NEG) || (issue.op == OP_HIGH_ZERO);
   assign shift_ok = (issue.op != OP_LOAD);
   assign both_acc = is_acc(issue.dest) &&
      (is_acc(issue.src_a) || (!issue.b_is_imm && is_acc(issue.src_b)));

   // ------------------------------------------------------------
   // Accumulator
   // ------------------------------------------------------------
   // Writes land the cycle they issue; no ordering against earlier writes
   // still in flight is enforced, so FPU results may retire out of order.
   always_ff @(posedge mclk) begin
      if (reset) begin
         acc_r <= `ACC_RESET;
      end else if (issue_valid && !both_acc) begin
         if (issue.dest == `GREG_ACC_PLAIN && plain_ok) begin
            acc_r <= alu_out;
         end else if (issue.dest == `GREG_ACC_SHIFT && shift_ok) begin
            acc_r <= {acc_r[30:0], alu_out[31]};
         end
      end
   end
   assign condition_code_accumulator = acc_r;

   // ------------------------------------------------------------
   // Result register
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         result <= '0;
      end else begin
         result.valid <= issue_valid && (issue.op != OP_FPU);
         result.dest <= issue.dest;
         result.value <= alu_out;
         result.writes_reg <= issue_valid && !is_acc(issue.dest) &&
            !(issue.op inside {OP_ASSERT_EQ, OP_JUMP_REL, OP_JUMP_IND, OP_FPU});
         result.trap <= issue_valid && (issue.op == OP_ASSERT_EQ) &&
            (a_eff != b_eff) && !(issue.src_a == `GREG_STACK_PTR &&
            issue.src_b == `GREG_STACK_PTR);
         result.branch <= issue_valid && (issue.op inside {OP_JUMP_REL, OP_JUMP_IND});
         result.target <= alu_out;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         unsupported <= 1'b0;
      end else begin
         unsupported <= issue_valid && (both_acc ||
            (issue.dest == `GREG_ACC_PLAIN && !plain_ok) ||
            (issue.dest == `GREG_ACC_SHIFT && !shift_ok));
      end
   end

   // ------------------------------------------------------------
   // Floating-point latency
   // ------------------------------------------------------------
   fpu_latency u_lat (
      .mclk(mclk),
      .reset(reset),
      .start(issue_valid && issue.op == OP_FPU),
      .denorm(fpu_denorm),
      .denormal_flush_select(denormal_flush_select),
      .busy(fpu_busy),
      .done(fpu_done_w)
   );
   always_ff @(posedge mclk) begin
      if (reset) begin
         fpu_done <= 1'b0;
      end else begin
         fpu_done <= fpu_done_w && !fpu_busy;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   plain_write_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.dest == `GREG_ACC_PLAIN && plain_ok && !both_acc
      |=> acc_r == $past(alu_out))
      else $error("plain alias write lost");
   shift_write_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.dest == `GREG_ACC_SHIFT && shift_ok && !both_acc
      |=> acc_r == {$past(acc_r[30:0]), $past(alu_out[31])})
      else $error("shift alias write wrong");
   acc_read_a: assert property (@(posedge mclk) disable iff (reset)
      issue.op != OP_FPU && issue.src_a == `GREG_ACC_PLAIN |-> a_eff == acc_r)
      else $error("accumulator read wrong");
   acc_read_b_a: assert property (@(posedge mclk) disable iff (reset)
      issue.op != OP_FPU && !issue.b_is_imm && issue.src_b == `GREG_ACC_PLAIN
      |-> b_eff == acc_r)
      else $error("accumulator read on second operand wrong");
   fpu_no_acc_a: assert property (@(posedge mclk) disable iff (reset)
      issue.op == OP_FPU |-> a_eff == issue.a_val)
      else $error("FPU saw accumulator");
   shift_read_a: assert property (@(posedge mclk) disable iff (reset)
      issue.op != OP_FPU && issue.src_a == `GREG_ACC_SHIFT |-> a_eff == acc_r)
      else $error("shift alias read not the accumulator");
   acc_idle_a: assert property (@(posedge mclk) disable iff (reset)
      !issue_valid |=> acc_r == $past(acc_r))
      else $error("accumulator changed without an issue");
   load_shift_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.op == OP_LOAD |=> acc_r == $past(acc_r))
      else $error("load changed accumulator");
   plain_reject_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.dest == `GREG_ACC_PLAIN && !plain_ok |=> unsupported)
      else $error("unsupported plain write not flagged");
   plain_ok_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.dest == `GREG_ACC_PLAIN && plain_ok && !both_acc
      |=> !unsupported)
      else $error("supported plain write flagged");
   shift_reject_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.dest == `GREG_ACC_SHIFT && !shift_ok |=> unsupported)
      else $error("load to shift alias not flagged");
   shift_ok_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.dest == `GREG_ACC_SHIFT && shift_ok && !both_acc
      |=> !unsupported)
      else $error("supported shift write flagged");
   both_keep_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && both_acc |=> unsupported && acc_r == $past(acc_r))
      else $error("accumulator as source and destination not refused");
   acc_no_reg_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && is_acc(issue.dest) |=> !result.writes_reg)
      else $error("accumulator write reached the register file");

   // ------------------------------------------------------------
   // Datapath checks
   // ------------------------------------------------------------
   imm_zero_ext_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.op == OP_ADD && issue.b_is_imm
      |=> result.value == $past(a_eff) + {24'h000000, $past(issue.imm[7:0])})
      else $error("short immediate not zero extended");
   const_low_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.op == OP_CONST_LOW
      |=> result.value == {`HALF_ZERO, $past(issue.imm)})
      else $error("low constant wrong");
   high_keep_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.op == OP_HIGH
      |=> result.value[15:0] == $past(issue.dest_old[15:0]))
      else $error("high constant lost low half");
   high_upper_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.op == OP_HIGH |=> result.value[31:16] == $past(issue.imm))
      else $error("high constant upper half wrong");
   neg_const_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.op == OP_NEG |=> result.value[31:16] == `HALF_ONES)
      else $error("negative constant upper half");
   neg_low_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.op == OP_NEG |=> result.value[15:0] == $past(issue.imm))
      else $error("negative constant lower half");
   high_zero_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.op == OP_HIGH_ZERO |=> result.value[15:0] == `HALF_ZERO)
      else $error("high zero lower half");
   high_zero_up_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.op == OP_HIGH_ZERO |=> result.value[31:16] == $past(issue.imm))
      else $error("high zero upper half");
   rel_target_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.op == OP_JUMP_REL |=> result.branch &&
      result.target == $past(issue.pc) +
      {{14{$past(issue.imm[15])}}, $past(issue.imm), 2'b00})
      else $error("relative jump target wrong");
   ind_target_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.op == OP_JUMP_IND
      |=> result.branch && result.target == $past(a_eff))
      else $error("indirect jump target wrong");
   noop_trap_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.op == OP_ASSERT_EQ && issue.src_a == `GREG_STACK_PTR &&
      issue.src_b == `GREG_STACK_PTR |=> !result.trap && !result.writes_reg)
      else $error("no-op assert trapped");
   // A real failed assert must still trap, or the no-op exemption proves nothing.
   trap_miss_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.op == OP_ASSERT_EQ && a_eff != b_eff &&
      issue.src_a != `GREG_STACK_PTR |=> result.trap)
      else $error("failed assert did not trap");
   funnel_byte_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.op == OP_FUNNEL &&
      issue.shift_count[2:0] == `BYTE_SEL_ZERO && issue.shift_count[4:3] == 2'h1
      |=> result.value == {$past(a_eff[23:0]), $past(b_eff[31:24])})
      else $error("byte aligned funnel shift wrong");
   byte_match_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.op == OP_BYTE_CMP && a_eff[7:0] == b_eff[7:0]
      |=> result.value[31])
      else $error("byte match missed");
   byte_any_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.op == OP_BYTE_CMP && lane_match(a_eff, b_eff)
      |=> result.value == `BOOL_TRUE)
      else $error("byte compare true value wrong");
   byte_miss_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.op == OP_BYTE_CMP && a_eff[31:24] != b_eff[31:24] &&
      a_eff[23:16] != b_eff[23:16] && a_eff[15:8] != b_eff[15:8] &&
      a_eff[7:0] != b_eff[7:0] |=> !result.value[31])
      else $error("byte compare false positive");
   byte_false_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.op == OP_BYTE_CMP && !lane_match(a_eff, b_eff)
      |=> result.value == `WORD_ZERO)
      else $error("byte compare false value wrong");
   fpu_quiet_a: assert property (@(posedge mclk) disable iff (reset)
      issue_valid && issue.op == OP_FPU |=> !result.valid && !result.writes_reg)
      else $error("floating-point issue gave an integer result");
   fpu_pulse_a: assert property (@(posedge mclk) disable iff (reset)
      fpu_done |=> !fpu_done)
      else $error("completion pulse longer than one cycle");
endmodule

// ==== verilog/ccg_map.svh ====
// Purpose: Named constants for the condition accumulator and constant generation datapath.
// Assumes: 32-bit data, global register numbers as 8-bit codes.
// Notes: Opcode codes are local encodings of this block's operation select port.
`ifndef CCG_MAP_SVH
`define CCG_MAP_SVH
`define GREG_ACC_PLAIN 8'h02
`define GREG_ACC_SHIFT 8'h03
`define GREG_STACK_PTR 8'h01
`define NOOP_VECTOR 8'h40
`define IMM8_W 8
`define HALF_W 16
`define HALF_ONES 16'hffff
`define HALF_ZERO 16'h0000
`define WORD_ZERO 32'h0000_0000
`define BOOL_TRUE 32'h8000_0000
`define BYTE_SEL_ZERO 3'h0
`define DISP_W 16
`define ACC_RESET 32'h0000_0000
`define FPU_FIXED_LAT 4'h2
`define FPU_DENORM_LAT 4'h6
`endif

// ==== verilog/ccg_pkg.sv ====
// Purpose: Types for the condition accumulator and constant generation datapath.
// Assumes: One core clock.
// Notes: Operation codes are one-hot so that illegal codes are easy to spot.
package ccg_pkg;
   typedef enum logic [15:0] {
      OP_ADD = 16'h0001,
      OP_SUB = 16'h0002,
      OP_CONST_LOW = 16'h0004,
      OP_HIGH = 16'h0008,
      OP_NEG = 16'h0010,
      OP_HIGH_ZERO = 16'h0020,
      OP_BYTE_CMP = 16'h0040,
      OP_FUNNEL = 16'h0080,
      OP_ASSERT_EQ = 16'h0100,
      OP_JUMP_REL = 16'h0200,
      OP_JUMP_IND = 16'h0400,
      OP_LOAD = 16'h0800,
      OP_FPU = 16'h1000,
      OP_LOGIC = 16'h2000
   } op_e;
   typedef struct packed {
      op_e op;
      logic [7:0] dest;
      logic [7:0] src_a;
      logic [7:0] src_b;
      logic b_is_imm;
      logic [15:0] imm;
      logic [4:0] shift_count;
      logic [31:0] a_val;
      logic [31:0] b_val;
      logic [31:0] dest_old;
      logic [31:0] pc;
   } issue_s;
   typedef struct packed {
      logic valid;
      logic [7:0] dest;
      logic [31:0] value;
      logic writes_reg;
      logic trap;
      logic branch;
      logic [31:0] target;
   } result_s;
endpackage

// ==== verilog/fpu_latency.sv ====
// Purpose: Latency counter for floating-point unit operations.
// Assumes: Denormal flag comes from the operand classifier on the same clock.
// Notes: With the flush select set, denormals never lengthen the operation.
`timescale 1ns/100ps
`include "ccg_map.svh"
module fpu_latency
   import ccg_pkg::*;
(
   input wire logic mclk, // core clock
   input wire logic reset, // synchronous reset
   input wire logic start, // one-cycle start of an FPU operation
   input wire logic denorm, // an operand or result is denormal
   input wire logic denormal_flush_select, // flush mode enable
   output logic busy, // operation in flight
   output logic done // one-cycle completion pulse
);
   logic [3:0] count_r;
   always_ff @(posedge mclk) begin
      if (reset) begin
         count_r <= 4'h0;
      end else if (start) begin
         count_r <= (denorm && !denormal_flush_select) ? `FPU_DENORM_LAT : `FPU_FIXED_LAT;
      end else if (count_r != 4'h0) begin
         count_r <= count_r - 4'h1;
      end
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         done <= 1'b0;
      end else begin
         done <= (count_r == 4'h1);
      end
   end
   assign busy = (count_r != 4'h0);
   flush_fixed_a: assert property (@(posedge mclk) disable iff (reset)
      start && denormal_flush_select && count_r == 4'h0 |-> ##3 done)
      else $error("flush mode latency not fixed");
endmodule

// ==== testbench/test_cond_code_accum_const_gen.sv ====
// Purpose: Self-checking bench for the accumulator, constant and compare execute stage.
// Assumes: One issue every other cycle; results are checked one cycle after issue.
// Notes: The bench keeps its own model of the accumulator; random data uses a fixed seed.
`timescale 1ns/100ps
module test_cond_code_accum_const_gen
   import ccg_pkg::*;
;
   logic mclk, reset, issue_valid, fpu_denorm, denormal_flush_select;
   issue_s issue, iv;
   result_s result;
   logic [31:0] condition_code_accumulator, acc_exp, ra, rb, exp;
   logic fpu_done, unsupported;
   logic [15:0] im;
   int n_fail, n_tests, cyc, n;
   op_e cops[4] = '{OP_CONST_LOW, OP_HIGH, OP_NEG, OP_HIGH_ZERO};

   cond_code_accum_const_gen cond_code_accum_const_gen_inst (
      .mclk(mclk), .reset(reset), .issue_valid(issue_valid), .issue(issue),
      .fpu_denorm(fpu_denorm), .denormal_flush_select(denormal_flush_select),
      .result(result), .condition_code_accumulator(condition_code_accumulator),
      .fpu_done(fpu_done), .unsupported(unsupported));

   always #5 mclk = ~mclk;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic issue_s mk(op_e op, logic [7:0] d, logic [7:0] sa, logic [15:0] imm_v,
                                 logic [31:0] a, logic [31:0] b, logic [31:0] old);
      mk = '{op: op, dest: d, src_a: sa, src_b: 8'h61, b_is_imm: 1'b0, imm: imm_v,
             shift_count: 5'h00, a_val: a, b_val: b, dest_old: old, pc: 32'h0000_0000};
   endfunction

   function automatic logic [31:0] const_exp(op_e op, logic [15:0] f, logic [31:0] old);
      case (op)
         OP_CONST_LOW: const_exp = {16'h0000, f};
         OP_HIGH: const_exp = {f, old[15:0]};
         OP_NEG: const_exp = {16'hffff, f};
         default: const_exp = {f, 16'h0000};
      endcase
   endfunction

   function automatic logic any_byte(logic [31:0] a, logic [31:0] b);
      any_byte = (a[7:0] == b[7:0]) || (a[15:8] == b[15:8]) ||
                 (a[23:16] == b[23:16]) || (a[31:24] == b[31:24]);
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h got %h", nm, e, g);
      end
   endtask

   // Inputs change by non-blocking assignment on the edge; checks wait 1 ns for outputs.
   task automatic run(input issue_s i);
      @(posedge mclk);
      issue <= i;
      issue_valid <= 1'b1;
      @(posedge mclk);
      issue_valid <= 1'b0;
      #1;
   endtask

   task automatic fpu_run(input logic dn, input logic fl, input int lat);
      @(posedge mclk);
      fpu_denorm <= dn;
      denormal_flush_select <= fl;
      run(mk(OP_FPU, 8'h60, 8'h60, 16'h0000, $urandom, $urandom, 32'h0));
      n = 1;
      while (fpu_done !== 1'b1 && n < 20) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk("fpu_latency", lat, n);
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         end_sim();
      end
   end

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      reset = 1'b1;
      issue_valid = 1'b0;
      fpu_denorm = 1'b0;
      denormal_flush_select = 1'b0;
      issue = mk(OP_ADD, 8'h60, 8'h60, 16'h0000, 32'h0, 32'h0, 32'h0);
      n_fail = 0;
      n_tests = 0;
      cyc = 0;
      void'($urandom(32'hfce176ea));
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      #1;
      chk("acc_reset", 32'h0, condition_code_accumulator);
      run(mk(OP_CONST_LOW, 8'h02, 8'h60, 16'h1234, 32'h0, 32'h0, 32'h0));
      chk("acc_plain", 32'h0000_1234, condition_code_accumulator);
      chk("acc_no_reg", 32'h0, {31'h0, result.writes_reg});
      run(mk(OP_ADD, 8'h03, 8'h60, 16'h0000, 32'h8000_0000, 32'h0, 32'h0));
      chk("acc_shift", 32'h0000_2469, condition_code_accumulator);
      acc_exp = 32'h0000_2469;
      for (int k = 0; k < 12; k++) begin
         im = 16'($urandom);
         ra = $urandom;
         run(mk(cops[k % 4], (k < 4) ? 8'h02 : 8'h60, 8'h60, im, 32'h0, 32'h0, ra));
         exp = const_exp(cops[k % 4], im, ra);
         chk("const_value", exp, result.value);
         if (k < 4)
            acc_exp = exp;
         chk("acc_const", acc_exp, condition_code_accumulator);
      end
      rb = $urandom;
      run(mk(OP_ADD, 8'h60, 8'h02, 16'h0000, $urandom, rb, 32'h0));
      chk("acc_read", acc_exp + rb, result.value);
      ra = $urandom;
      im = 16'($urandom);
      iv = mk(OP_ADD, 8'h60, 8'h60, im, ra, 32'hffff_ffff, 32'h0);
      iv.b_is_imm = 1'b1;
      run(iv);
      chk("imm_add", ra + {24'h0, im[7:0]}, result.value);
      chk("imm_valid", 32'h1, {31'h0, result.valid});
      chk("imm_writes", 32'h1, {31'h0, result.writes_reg});
      chk("imm_dest", 32'h60, {24'h0, result.dest});
      run(mk(OP_LOGIC, 8'h02, 8'h60, 16'h0000, 32'hffff_ffff, 32'h1, 32'h0));
      chk("refuse_logic", {31'h0, 1'b1}, {31'h0, unsupported});
      run(mk(OP_LOAD, 8'h03, 8'h60, 16'h0000, 32'hffff_ffff, 32'h1, 32'h0));
      chk("refuse_load", {31'h0, 1'b1}, {31'h0, unsupported});
      run(mk(OP_ADD, 8'h03, 8'h02, 16'h0000, 32'hffff_ffff, 32'h1, 32'h0));
      chk("refuse_both", {31'h0, 1'b1}, {31'h0, unsupported});
      chk("acc_kept", acc_exp, condition_code_accumulator);
      run(mk(OP_LOGIC, 8'h03, 8'h60, 16'h0000, 32'hffff_ffff, 32'h8000_0000, 32'h0));
      acc_exp = {acc_exp[30:0], 1'b1};
      chk("shift_logic", acc_exp, condition_code_accumulator);
      chk("accept_flag", 32'h0, {31'h0, unsupported});
      ra = $urandom;
      rb = $urandom;
      run(mk(OP_SUB, 8'h02, 8'h60, 16'h0000, ra, rb, 32'h0));
      chk("acc_sub", ra - rb, condition_code_accumulator);
      acc_exp = ra - rb;
      for (int k = 0; k < 16; k++) begin
         ra = $urandom;
         rb = $urandom;
         if (k % 2 == 1)
            rb[8 * (k % 8 / 2) +: 8] = ra[8 * (k % 8 / 2) +: 8];
         if (k == 14)
            rb = ~ra;
         run(mk(OP_BYTE_CMP, 8'h60, 8'h60, 16'h0000, ra, rb, 32'h0));
         chk("byte_cmp", {any_byte(ra, rb), 31'h0}, {result.value[31], 31'h0});
      end
      ra = $urandom;
      iv = mk(OP_ASSERT_EQ, 8'h60, 8'h01, 16'h0040, ra, ra, 32'h0);
      iv.src_b = 8'h01;
      run(iv);
      chk("noop_trap", 32'h0, {31'h0, result.trap});
      chk("noop_write", 32'h0, {31'h0, result.writes_reg});
      chk("noop_acc", acc_exp, condition_code_accumulator);
      iv = mk(OP_ASSERT_EQ, 8'h60, 8'h60, 16'h0040, ra, ~ra, 32'h0);
      run(iv);
      chk("assert_trap", 32'h1, {31'h0, result.trap});
      for (int k = 0; k < 4; k++) begin
         ra = $urandom;
         rb = $urandom;
         iv = mk(OP_FUNNEL, 8'h60, 8'h60, 16'h0000, ra, rb, 32'h0);
         iv.shift_count = 5'(k * 8);
         run(iv);
         exp = 32'(({ra, rb} << (k * 8)) >> 32);
         chk("funnel", exp, result.value);
      end
      ra = $urandom;
      im = 16'($urandom);
      iv = mk(OP_JUMP_REL, 8'h60, 8'h60, im, 32'h0, 32'h0, 32'h0);
      iv.pc = ra;
      run(iv);
      chk("rel_target", ra + {{14{im[15]}}, im, 2'b00}, result.target);
      chk("rel_branch", 32'h1, {31'h0, result.branch});
      fpu_run(1'b0, 1'b0, 4);
      fpu_run(1'b1, 1'b0, 8);
      fpu_run(1'b1, 1'b1, 4);
      end_sim();
   end
endmodule
